// ===== inc/rbf_consts.vh
// Constants for the receive baseband filter chain: register offsets, field layouts, reset
// values and timing figures.
// Assumes a single 100 MHz logic clock and a plain address/strobe register port.
`ifndef RBF_CONSTS_VH
`define RBF_CONSTS_VH
`define RBF_ADDR_W 4
`define RBF_REG_MODUL 4'h0
`define RBF_REG_BW 4'h1
`define RBF_REG_DIGITAL_GAIN_CONTROL 4'h2
`define RBF_REG_THRESH 4'h3
`define RBF_REG_BITPER 4'h4
`define RBF_REG_RSSI 4'h5
`define RBF_REG_STATUS 4'h6
`define RBF_REG_GAIN 4'h7
`define RBF_REG_IFSHIFT 4'h8
`define RBF_MOD_FSK 2'h0
`define RBF_MOD_OOK 2'h1
`define RBF_MODUL_RST 8'h00
`define RBF_BW_RST 8'h55
`define RBF_DCC_RST 3'h2
`define RBF_DIGITAL_GAIN_CONTROL_RST 8'h30
`define RBF_DIGITAL_GAIN_CONTROL_LOWIDX 8'h20
`define RBF_DIGITAL_GAIN_CONTROL_NORMAL 8'h30
`define RBF_THRESH_RST 8'hE4
`define RBF_BITPER_RST 16'h0D05
`define RBF_DIGITAL_GAIN_CONTROL_BITS 2
`define RBF_RSSI_BITS 2
`define RBF_WAIT_HITS 2
`define RBF_FIR_TAPS 16
`define RBF_GAIN_UNITY 8'h10
`define RBF_REF_HZ 32000000
`define RBF_CLK_HZ 100000000
`define RBF_CAL_TIME_US 20
`define RBF_CAL_CYC ((`RBF_CAL_TIME_US * (`RBF_CLK_HZ / 1000000)))
`endif

// ===== hw/rbf_chain.v
// Receive baseband chain: decimation, digital gain, channel FIR, DC removal, OOK image
// filter, signal-strength estimator and wait-state detector.
// Assumes 1-bit converter streams on pins and a host on the plain register port.
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "rbf_consts.vh"

module rbf_chain #(
  parameter DEC = 32,
  parameter CAL_CYC = `RBF_CAL_CYC
) (
  // Clock and reset
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  // Converter bit streams, synthesizer start-up and front-end gain frozen flag
  input wire ADC_I_IN,
  input wire ADC_Q_IN,
  input wire SYNTH_START_IN,
  input wire FRONT_GAIN_FROZEN_IN,
  // Register port
  input wire [3:0] ADDR_IN,
  input wire [7:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  output reg [7:0] RDATA_OUT,
  // Filtered baseband to demodulators, wait state and calibration busy
  output reg [15:0] I_OUT,
  output reg [15:0] Q_OUT,
  output reg SAMPLE_VALID_OUT,
  output reg RX_WAIT_OUT,
  output reg CAL_BUSY_OUT
);

  // Divider for the bandwidth in Hz; mantissa code 11 is treated as 24.
  function [31:0] bw_hz;
    input [1:0] mant;
    input [2:0] expo;
    input ook;
    reg [7:0] m;
    begin
      m = (mant == 2'h0) ? 8'h10 : (mant == 2'h1) ? 8'h14 : 8'h18;
      bw_hz = `RBF_REF_HZ / ({24'h000000, m} << ({29'h0, expo} + 32'd2 + {31'h0, ook}));
    end
  endfunction

  reg [2:0] ai_s_q;
  reg [2:0] aq_s_q;
  reg [1:0] frz_s_q;
  reg [2:0] st_s_q;
  wire ai = ai_s_q[1];
  wire aq = aq_s_q[1];

  reg [7:0] modul_q;
  reg [7:0] bw_q;
  reg [7:0] digital_gain_control_q;
  reg [7:0] thresh_q;
  reg [7:0] rssi_q;
  reg [7:0] gain_q;
  reg [15:0] bitper_q;
  wire [1:0] mod_sel = modul_q[1:0];
  wire ook = (mod_sel == `RBF_MOD_OOK);
  wire [2:0] dcc_sel = bw_q[7:5];
  wire [1:0] mant = bw_q[4:3];
  wire [2:0] expo = bw_q[2:0];
  wire digital_gain_control_on = (digital_gain_control_q == `RBF_DIGITAL_GAIN_CONTROL_LOWIDX) || (digital_gain_control_q == `RBF_DIGITAL_GAIN_CONTROL_NORMAL);

  wire [31:0] bw_now = bw_hz(mant, expo, 1'b0);
  wire [31:0] if_hz = bw_hz(mant, expo, ook) >> 1;

  // Synchronisers and synthesizer-start edge.
  always @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ai_s_q <= 3'h0;
      aq_s_q <= 3'h0;
      st_s_q <= 3'h0;
      frz_s_q <= 2'h0;
    end
    else
    begin
      ai_s_q <= {ai_s_q[1:0], ADC_I_IN};
      aq_s_q <= {aq_s_q[1:0], ADC_Q_IN};
      st_s_q <= {st_s_q[1:0], SYNTH_START_IN};
      frz_s_q <= {frz_s_q[0], FRONT_GAIN_FROZEN_IN};
    end
  end
  wire synth_rise = st_s_q[1] & ~st_s_q[2];

  // Decimator: count ones over DEC cycles, centred to signed.
  reg [15:0] dcnt_q;
  reg [15:0] acc_i_q;
  reg [15:0] acc_q_q;
  reg signed [15:0] di_q;
  reg signed [15:0] dq_q;
  reg dec_v_q;
  always @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      dcnt_q <= 16'h0000;
      acc_i_q <= 16'h0000;
      acc_q_q <= 16'h0000;
      di_q <= 16'h0000;
      dq_q <= 16'h0000;
      dec_v_q <= 1'b0;
    end
    else
    begin
      dec_v_q <= 1'b0;
      if (dcnt_q == DEC[15:0] - 16'h0001)
      begin
        dcnt_q <= 16'h0000;
        di_q <= $signed((acc_i_q + {15'h0, ai}) << 1) - $signed(DEC[15:0]);
        dq_q <= $signed((acc_q_q + {15'h0, aq}) << 1) - $signed(DEC[15:0]);
        acc_i_q <= 16'h0000;
        acc_q_q <= 16'h0000;
        dec_v_q <= 1'b1;
      end
      else
      begin
        dcnt_q <= dcnt_q + 16'h0001;
        acc_i_q <= acc_i_q + {15'h0, ai};
        acc_q_q <= acc_q_q + {15'h0, aq};
      end
    end
  end

  // Channel FIR: boxcar over the last 16 decimated samples; the length is fixed
  // and ignores the bandwidth setting, and the filter is fed at the decimated rate.
  reg signed [15:0] tap_i [0:15];
  reg signed [15:0] tap_q [0:15];
  reg signed [19:0] fsum_i;
  reg signed [19:0] fsum_q;
  integer k;
  integer t;
  always @*
  begin
    fsum_i = 20'h00000;
    fsum_q = 20'h00000;
    for (k = 0; k < `RBF_FIR_TAPS; k = k + 1)
    begin
      fsum_i = fsum_i + {{4{tap_i[k][15]}}, tap_i[k]};
      fsum_q = fsum_q + {{4{tap_q[k][15]}}, tap_q[k]};
    end
  end

  // DC tracker: cutoff shift grows by one per code, halving the cutoff.
  // The tracker keeps eight fraction bits so slow cutoffs still move it.
  reg signed [23:0] dc_i_q;
  reg signed [23:0] dc_q_q;
  wire [4:0] dc_sh = 5'd4 + {2'h0, dcc_sel};
  wire signed [15:0] fi = fsum_i[19:4];
  wire signed [15:0] fq = fsum_q[19:4];
  wire signed [15:0] ci = fi - dc_i_q[23:8];
  wire signed [15:0] cq = fq - dc_q_q[23:8];

  // Image filter for OOK: one-pole complex rotation estimate, bypassed for FSK.
  reg signed [15:0] im_i_q;
  reg signed [15:0] im_q_q;
  wire byp = (mod_sel == `RBF_MOD_FSK);
  wire signed [15:0] oi = byp ? ci : (ci + im_i_q) >>> 1;
  wire signed [15:0] oq = byp ? cq : (cq - im_q_q) >>> 1;

  // Digital gain in 1/16 steps.
  wire signed [23:0] gi = oi * $signed({1'b0, gain_q});
  wire signed [23:0] gq = oq * $signed({1'b0, gain_q});
  wire [15:0] mag = (oi[15] ? -oi : oi) + (oq[15] ? -oq : oq);

  always @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      for (t = 0; t < `RBF_FIR_TAPS; t = t + 1)
      begin
        tap_i[t] <= 16'h0000;
        tap_q[t] <= 16'h0000;
      end
      dc_i_q <= 24'h000000;
      dc_q_q <= 24'h000000;
      im_i_q <= 16'h0000;
      im_q_q <= 16'h0000;
      I_OUT <= 16'h0000;
      Q_OUT <= 16'h0000;
      SAMPLE_VALID_OUT <= 1'b0;
    end
    else
    begin
      SAMPLE_VALID_OUT <= dec_v_q;
      if (dec_v_q)
      begin
        tap_i[0] <= di_q;
        tap_q[0] <= dq_q;
        // Taps move only on a decimated sample, so the filter runs at the reduced rate.
        for (t = 1; t < `RBF_FIR_TAPS; t = t + 1)
        begin
          tap_i[t] <= tap_i[t-1];
          tap_q[t] <= tap_q[t-1];
        end
        // The step is made signed first; a plain concatenation would shift a negative
        // error in as a huge positive one.
        dc_i_q <= dc_i_q + (($signed({{8{ci[15]}}, ci}) <<< 8) >>> dc_sh);
        dc_q_q <= dc_q_q + (($signed({{8{cq[15]}}, cq}) <<< 8) >>> dc_sh);
        im_i_q <= cq;
        im_q_q <= ci;
        I_OUT <= gi[19:4];
        Q_OUT <= gq[19:4];
      end
    end
  end

  // Bit-period timer: two bit periods per gain and strength window.
  reg [15:0] bcnt_q;
  reg [1:0] bits_q;
  reg [15:0] peak_q;
  reg [7:0] rssi_raw_q;
  reg [1:0] hits_q;
  // A bit period written below the running count ends the bit at once rather than
  // letting the counter wrap through its whole range.
  wire bit_tick = (bcnt_q >= bitper_q);
  wire win_end = bit_tick && (bits_q == `RBF_DIGITAL_GAIN_CONTROL_BITS - 1);
  // Strength in half-dB codes: 12 codes per doubling of magnitude.
  function [7:0] to_halfdb;
    input [15:0] v;
    integer j;
    reg [7:0] r;
    begin
      r = 8'h00;
      for (j = 0; j < 16; j = j + 1)
        if (v[j])
          r = 8'hFF - (8'd12 * j[7:0]);
      to_halfdb = r;
    end
  endfunction

  always @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      bcnt_q <= 16'h0000;
      bits_q <= 2'h0;
      peak_q <= 16'h0000;
      rssi_raw_q <= 8'hFF;
      hits_q <= 2'h0;
      gain_q <= `RBF_GAIN_UNITY;
      RX_WAIT_OUT <= 1'b1;
    end
    else
    begin
      bcnt_q <= bit_tick ? 16'h0000 : bcnt_q + 16'h0001;
      if (bit_tick)
        bits_q <= win_end ? 2'h0 : bits_q + 2'h1;
      if (SAMPLE_VALID_OUT && mag > peak_q)
        peak_q <= mag;
      if (win_end)
      begin
        peak_q <= 16'h0000;
        rssi_raw_q <= to_halfdb(peak_q);
        // Lower code means stronger; count two in a row over threshold.
        if (to_halfdb(peak_q) < thresh_q)
          hits_q <= (hits_q == `RBF_WAIT_HITS) ? hits_q : hits_q + 2'h1;
        else
          hits_q <= 2'h0;
        if (hits_q == `RBF_WAIT_HITS - 1 && to_halfdb(peak_q) < thresh_q)
          RX_WAIT_OUT <= 1'b0;
        // The frozen front-end flag is deliberately not consulted here.
        if (digital_gain_control_on)
        begin
          if (peak_q[15:12] != 4'h0 && gain_q > 8'h01)
            gain_q <= gain_q - 8'h01;
          else if (peak_q[15:10] == 6'h00 && gain_q < 8'hFF)
            gain_q <= gain_q + 8'h01;
        end
      end
      if (!digital_gain_control_on)
        gain_q <= `RBF_GAIN_UNITY;
    end
  end

  // Start-up calibration on each synthesizer start.
  reg [31:0] cal_q;
  always @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      cal_q <= 32'h00000000;
      CAL_BUSY_OUT <= 1'b0;
    end
    else if (synth_rise)
    begin
      cal_q <= CAL_CYC;
      CAL_BUSY_OUT <= 1'b1;
    end
    else if (cal_q != 32'h00000000)
      cal_q <= cal_q - 32'h00000001;
    else
      CAL_BUSY_OUT <= 1'b0;
  end

  // Register file.
  always @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      modul_q <= `RBF_MODUL_RST;
      bw_q <= `RBF_BW_RST;
      digital_gain_control_q <= `RBF_DIGITAL_GAIN_CONTROL_RST;
      thresh_q <= `RBF_THRESH_RST;
      bitper_q <= `RBF_BITPER_RST;
      rssi_q <= 8'hFF;
      RDATA_OUT <= 8'h00;
    end
    else
    begin
      if (rssi_raw_q < thresh_q)
        rssi_q <= rssi_raw_q;
      if (WR_IN)
      begin
        case (ADDR_IN)
          `RBF_REG_MODUL: modul_q <= WDATA_IN;
          `RBF_REG_BW: bw_q <= WDATA_IN;
          `RBF_REG_DIGITAL_GAIN_CONTROL: digital_gain_control_q <= WDATA_IN;
          `RBF_REG_THRESH: thresh_q <= WDATA_IN;
          `RBF_REG_BITPER: bitper_q <= {8'h00, WDATA_IN};
          default: ;
        endcase
      end
      // Read data is zero outside a read cycle, so a shared host bus sees no stale value.
      RDATA_OUT <= 8'h00;
      if (RD_IN)
      begin
        case (ADDR_IN)
          `RBF_REG_MODUL: RDATA_OUT <= modul_q;
          `RBF_REG_BW: RDATA_OUT <= bw_q;
          `RBF_REG_DIGITAL_GAIN_CONTROL: RDATA_OUT <= digital_gain_control_q;
          `RBF_REG_THRESH: RDATA_OUT <= thresh_q;
          `RBF_REG_BITPER: RDATA_OUT <= bitper_q[7:0];
          `RBF_REG_RSSI: RDATA_OUT <= rssi_q;
          `RBF_REG_STATUS: RDATA_OUT <= {5'h00, CAL_BUSY_OUT, digital_gain_control_on, RX_WAIT_OUT};
          `RBF_REG_GAIN: RDATA_OUT <= gain_q;
          `RBF_REG_IFSHIFT: RDATA_OUT <= ook ? if_hz[17:10] : 8'h00;
          default: RDATA_OUT <= 8'h00;
        endcase
      end
    end
  end

  wire unused_ok = |bw_now[31:0] | frz_s_q[1] | ai_s_q[2] | aq_s_q[2];

endmodule // rbf_chain

// ===== tb/rbf_chain_checker.sv
// Port checker for the receive baseband chain.
// Assumes binding onto rbf_chain; sees its top-level ports only.
`timescale 1ns/1ps
module rbf_chain_checker #(
  parameter DEC = 32,
  parameter CAL_CYC = 10
) (
  // Clock and reset
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  // Inputs
  input wire [3:0] ADDR_IN,
  input wire [7:0] WDATA_IN,
  input wire WR_IN,
  input wire RD_IN,
  input wire SYNTH_START_IN,
  // Outputs
  input wire [7:0] RDATA_OUT,
  input wire SAMPLE_VALID_OUT,
  input wire RX_WAIT_OUT,
  input wire CAL_BUSY_OUT
);
  localparam int CAL_TAIL = CAL_CYC - 7;
  reg [7:0] digital_gain_control_q;
  reg bw_wr_q;
  reg seen_q;
  reg [7:0] gap_q;
  reg [2:0] since_q;
  wire digital_gain_control_on;
  assign digital_gain_control_on = (digital_gain_control_q == 8'h20) || (digital_gain_control_q == 8'h30);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Shadow of the gain test register, so gain and status reads can be judged.
  always @(posedge REF_CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      digital_gain_control_q <= 8'h30;
      bw_wr_q <= 1'b0;
      seen_q <= 1'b0;
      gap_q <= 8'h00;
      since_q <= 3'h0;
    end
    else
    begin
      if (WR_IN && ADDR_IN == 4'h2) digital_gain_control_q <= WDATA_IN;
      if (WR_IN && ADDR_IN == 4'h1) bw_wr_q <= 1'b1;
      seen_q <= seen_q | SAMPLE_VALID_OUT;
      gap_q <= SAMPLE_VALID_OUT ? 8'h00 : gap_q + 8'h01;
      if (since_q != 3'h7) since_q <= since_q + 3'h1;
    end
  end
  a_valid_single: assert property (SAMPLE_VALID_OUT |=> !SAMPLE_VALID_OUT)
    else $error("valid too long");
  a_valid_period: assert property (SAMPLE_VALID_OUT && seen_q |-> gap_q == DEC - 1)
    else $error("valid spacing");
  a_cal_start: assert property ($rose(SYNTH_START_IN) |-> ##[1:4] CAL_BUSY_OUT)
    else $error("calibration not started");
  a_cal_length: assert property ($rose(CAL_BUSY_OUT) |->
    CAL_BUSY_OUT [*8] ##CAL_TAIL CAL_BUSY_OUT ##1 !CAL_BUSY_OUT)
    else $error("calibration length");
  a_gain_unity: assert property ($past(RD_IN) && $past(ADDR_IN) == 4'h7
    && !$past(digital_gain_control_on) |-> RDATA_OUT == 8'h10)
    else $error("gain not unity");
  a_status_gain: assert property ($past(RD_IN) && $past(ADDR_IN) == 4'h6
    |-> RDATA_OUT[1] == $past(digital_gain_control_on))
    else $error("gain enable flag");
  a_dcc_default: assert property ($past(RD_IN) && $past(ADDR_IN) == 4'h1
    && !$past(bw_wr_q) |-> RDATA_OUT[7:5] == 3'h2)
    else $error("cutoff default");
  a_wait_early: assert property (since_q < 3'h4 |-> RX_WAIT_OUT)
    else $error("wait left early");
  a_read_quiet: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
    else $error("read data without read");
endmodule // rbf_chain_checker

bind rbf_chain rbf_chain_checker #(.DEC(DEC), .CAL_CYC(CAL_CYC)) u_chk (
  .REF_CLK_IN(REF_CLK_IN),
  .RST_N_IN(RST_N_IN),
  .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN),
  .RD_IN(RD_IN),
  .SYNTH_START_IN(SYNTH_START_IN),
  .RDATA_OUT(RDATA_OUT),
  .SAMPLE_VALID_OUT(SAMPLE_VALID_OUT),
  .RX_WAIT_OUT(RX_WAIT_OUT),
  .CAL_BUSY_OUT(CAL_BUSY_OUT)
);

// ===== tb/rbf_adc_model.sv
// Converter model: first-order sigma-delta bit streams on I and Q.
// Assumes the bench sets the level; Q carries the mirrored level.
`timescale 1ns/1ps
module rbf_adc_model (
  // Clock, reset and level
  input wire clk_in,
  input wire rst_n_in,
  input wire [7:0] level_in,
  // Streams
  output wire i_bit_out,
  output wire q_bit_out
);
  reg [8:0] i_acc_q;
  reg [8:0] q_acc_q;
  assign i_bit_out = i_acc_q[8];
  assign q_bit_out = q_acc_q[8];
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      i_acc_q <= 9'h000;
      q_acc_q <= 9'h000;
    end
    else
    begin
      i_acc_q <= {1'b0, i_acc_q[7:0]} + {1'b0, level_in};
      q_acc_q <= {1'b0, q_acc_q[7:0]} + {1'b0, ~level_in};
    end
  end
endmodule // rbf_adc_model

// ===== tb/rbf_chain_test.sv
// Self-checking bench for the receive baseband chain.
// Assumes the chain's register map and a 100 MHz clock.
`timescale 1ns/1ps
module rbf_chain_test;
  localparam DEC = 32;
  localparam CAL = 10;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg wr_en = 1'b0;
  reg rd_en = 1'b0;
  reg start = 1'b0;
  reg frozen = 1'b0;
  reg [7:0] level = 8'h40;
  wire adc_i;
  wire adc_q;
  wire [7:0] rdata;
  wire [15:0] i_out;
  wire [15:0] q_out;
  wire valid;
  wire rx_wait;
  wire cal_busy;
  integer fails = 0;
  integer n_compared = 0;
  always #5 clk = ~clk;
  rbf_adc_model adc (.clk_in(clk), .rst_n_in(rst_n), .level_in(level),
    .i_bit_out(adc_i), .q_bit_out(adc_q));
  // Calibration is shortened so its busy span can be counted exactly.
  rbf_chain #(.DEC(DEC), .CAL_CYC(CAL)) dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
    .ADC_I_IN(adc_i), .ADC_Q_IN(adc_q), .SYNTH_START_IN(start),
    .FRONT_GAIN_FROZEN_IN(frozen), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_en),
    .RD_IN(rd_en), .RDATA_OUT(rdata), .I_OUT(i_out), .Q_OUT(q_out), .SAMPLE_VALID_OUT(valid),
    .RX_WAIT_OUT(rx_wait), .CAL_BUSY_OUT(cal_busy));
  function [7:0] if_code(input integer m, input integer e);
    if_code = 8'(((32000000 / (m * (1 << (e + 3)))) / 2) >> 10);
  endfunction
  task check(input string nm, input [7:0] exp, input [7:0] seen);
  begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task wr(input [3:0] a, input [7:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  end
  endtask
  task rd(input [3:0] a, input [7:0] exp, input string nm);
  begin
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(nm, exp, rdata);
  end
  endtask
  task peek(input [3:0] a, output [7:0] v);
  begin
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    v = rdata;
  end
  endtask
  task t_defaults;
  begin
    rd(4'h0, 8'h00, "modulation");
    rd(4'h1, 8'h55, "bandwidth");
    rd(4'h2, 8'h30, "gain test");
    rd(4'h3, 8'hE4, "threshold");
    rd(4'h6, 8'h03, "status");
    rd(4'hF, 8'h00, "unmapped");
    wr(4'h3, 8'h00);
    $display("defaults done");
  end
  endtask
  task t_digital_gain_control;
    integer k;
    reg [7:0] v;
    reg on;
  begin
    for (k = 0; k < 4; k = k + 1)
    begin
      v = (k == 0) ? 8'h00 : (k == 1) ? 8'h20 : (k == 2) ? 8'h31 : 8'h30;
      on = (k == 1) || (k == 3);
      wr(4'h2, v);
      rd(4'h6, {6'h00, on, 1'b1}, "status");
      if (!on)
        rd(4'h7, 8'h10, "gain");
    end
    $display("gain control done");
  end
  endtask
  task t_bw;
    integer k;
    reg [7:0] v;
  begin
    for (k = 0; k < 8; k = k + 1)
    begin
      v = 8'((k << 5) | ((k % 3) << 3) | (7 - k));
      wr(4'h1, v);
      rd(4'h1, v, "bandwidth");
    end
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h40);
    rd(4'h8, if_code(16, 0), "if shift");
    wr(4'h1, 8'h51);
    rd(4'h8, if_code(24, 1), "if shift");
    wr(4'h0, 8'h00);
    wr(4'h8, 8'hFF);
    rd(4'h8, 8'h00, "if shift");
    $display("bandwidth done");
  end
  endtask
  task t_run;
    integer n;
    integer c;
  begin
    n = 0;
    c = 0;
    @(posedge clk);
    start <= 1'b1;
    frozen <= 1'b1;
    level <= 8'hC0;
    repeat (DEC * 24)
    begin
      @(posedge clk);
      #1;
      if (cal_busy === 1'b1)
        c = c + 1;
      if (valid === 1'b1)
        n = n + 1;
    end
    start <= 1'b0;
    check("cal busy", 8'(CAL + 1), 8'(c));
    check("valid count", 8'h18, 8'(n));
    check("i sign", 8'h00, {7'h00, i_out[15]});
    check("q sign", 8'h01, {7'h00, q_out[15]});
    check("wait state", 8'h01, {7'h00, rx_wait});
    $display("stream done");
  end
  endtask
  // Short bit period: a window is 128 cycles, so two gain reads 128 cycles apart
  // straddle exactly one window end.
  task t_wait;
    reg [7:0] g0;
    reg [7:0] g1;
    reg [7:0] s;
  begin
    wr(4'h4, 8'h3F);
    wr(4'h3, 8'hFF);
    repeat (DEC * 20) @(posedge clk);
    #1;
    check("wait state", 8'h00, {7'h00, rx_wait});
    peek(4'h7, g0);
    repeat (126) @(posedge clk);
    peek(4'h7, g1);
    check("gain step", g0 + 8'h01, g1);
    peek(4'h5, s);
    check("strength shown", 8'h01, {7'h00, s != 8'hFF});
    $display("wait state done");
  end
  endtask
  task stop_test;
  begin
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults;
    t_digital_gain_control;
    t_bw;
    t_run;
    t_wait;
    stop_test;
  end
  initial
  begin
    #50000;
    fails = fails + 1;
    stop_test;
  end
endmodule // rbf_chain_test
